//--- pkg/bypass_led_pkg.sv
`default_nettype none
package bypass_led_pkg;
	// Clock and blink timing
	localparam int CLK_HZ           = 10_000_000;
	localparam int BLINK_PERIOD_MS  = 1000;
	localparam int BLINK_PERIOD_CYC = BLINK_PERIOD_MS * (CLK_HZ / 1000);
	localparam int LONG_DUTY_PCT    = 50;
	localparam int SHORT_DUTY_PCT   = 15;
	localparam int DOUBLE_ON_PCT    = 10;
	localparam int PHASE_W          = 24;
	// Heartbeat
	localparam int HEARTBEAT_COUNT  = 500;
	localparam int HB_CNT_W         = 9;
	// Register port
	localparam int ADDR_W           = 8;
	localparam int DATA_W           = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_COUNT  = 8'h08;
	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
	localparam int CTRL_LAMP_TEST_BIT  = 0;
	localparam int COUNT_SCAN_LSB      = 16;
	// Identifier characters
	localparam logic [7:0] BYPASS_PREFIX = 8'h5A;
	localparam logic [7:0] MON_PREFIX    = 8'h55;
	localparam logic [7:0] MON_BYPASS    = 8'h42;
	localparam logic [7:0] MON_GRP1      = 8'h31;
	localparam logic [7:0] MON_GRP2      = 8'h32;
	localparam logic [7:0] MON_GRP4      = 8'h34;
	localparam logic [7:0] MON_GRP5      = 8'h35;

	typedef enum logic [1:0] {
		OP_OFF  = 2'b00,
		OP_AUTO = 2'b01,
		OP_HAND = 2'b10
	} op_mode_e;

	typedef enum logic [4:0] {
		PAT_OFF    = 5'b00001,
		PAT_SOLID  = 5'b00010,
		PAT_LONG   = 5'b00100,
		PAT_SHORT  = 5'b01000,
		PAT_DOUBLE = 5'b10000
	} lamp_pat_e;

	typedef struct packed {
		op_mode_e mode;
		logic     running;
		logic     dc_brake;
		logic     zero_ref;
		logic     decel;
		logic     pi_sleep;
		logic     ready;
		logic     run_cmd;
		logic     cycle_run;
		logic     fast_stop;
	} drive_state_s;

	typedef struct packed {
		logic [7:0] prefix;
		logic [7:0] second;
		logic       is_monitor;
		logic       in_bypass_copy;
	} param_id_s;

	typedef struct packed {
		logic auto_lamp;
		logic hand_lamp;
	} lamp_pair_s;
endpackage
`default_nettype wire

//--- rtl/bypass_status_indicator_logic.sv
`default_nettype none
module bypass_status_indicator_logic
	import bypass_led_pkg::*;
#(
	parameter int BLINK_CYC = BLINK_PERIOD_CYC
) (
	// Clock, reset, enable
	input  wire logic              clock_i,
	input  wire logic              reset_i,
	input  wire logic              enable_i,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_write_i,
	input  wire logic              reg_read_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	// Serial link activity
	input  wire logic              link_transmit_i,
	input  wire logic              link_receive_i,
	// Processing events
	input  wire logic              round_done_i,
	input  wire logic              scan_done_i,
	// Fault sources
	input  wire logic              fault_active_i,
	input  wire logic              alarm_active_i,
	input  wire logic              setting_consistency_error_i,
	input  wire logic              tune_fault_i,
	// Drive and keypad state
	input  wire drive_state_s      drive_state_i,
	input  wire logic              key_auto_i,
	input  wire logic              key_hand_i,
	input  wire logic              programming_mode_i,
	// Parameter display
	input  wire param_id_s         param_id_i,
	input  wire logic              drive_powered_i,
	input  wire logic              edit_req_i,
	// Indicators
	output logic                   module_status_led_o,
	output logic                   network_status_led_o,
	output logic                   round_heartbeat_led_o,
	output logic                   scan_heartbeat_led_o,
	output logic                   fault_indicator_o,
	output lamp_pair_s             lamps_o,
	// Keypad and display results
	output logic                   auto_key_o,
	output logic                   hand_key_o,
	output logic                   show_value_o,
	output logic                   show_dashes_o,
	output logic                   edit_accept_o,
	output logic                   edit_reject_o
);

	// Blink thresholds inside one period, and the last heartbeat count
	localparam logic [PHASE_W-1:0] PH_LAST   = PHASE_W'(BLINK_CYC - 1);
	localparam logic [PHASE_W-1:0] PH_LONG   = PHASE_W'(BLINK_CYC * LONG_DUTY_PCT / 100);
	localparam logic [PHASE_W-1:0] PH_SHORT  = PHASE_W'(BLINK_CYC * SHORT_DUTY_PCT / 100);
	localparam logic [PHASE_W-1:0] PH_DBL    = PHASE_W'(BLINK_CYC * DOUBLE_ON_PCT / 100);
	localparam logic [HB_CNT_W-1:0] HB_LAST  = HB_CNT_W'(HEARTBEAT_COUNT - 1);

	// Pattern choice for one lamp; double blink cause differs per mode
	function automatic lamp_pat_e pick_pattern(input drive_state_s s, input logic is_auto);
		logic dbl;
		dbl = is_auto ? s.fast_stop : s.cycle_run;
		if (dbl)
			pick_pattern = PAT_DOUBLE;
		else if (s.pi_sleep || (s.running && (s.zero_ref || s.decel)))
			pick_pattern = PAT_LONG;
		else if (s.running || s.dc_brake)
			pick_pattern = PAT_SOLID;
		else if (s.ready && !s.run_cmd)
			pick_pattern = PAT_SHORT;
		else
			pick_pattern = PAT_OFF;
	endfunction

	// Lamp level for a pattern at a phase of the blink period
	function automatic logic pattern_on(input lamp_pat_e p, input logic [PHASE_W-1:0] ph);
		case (p)
			PAT_OFF:    pattern_on = 1'b0;
			PAT_SOLID:  pattern_on = 1'b1;
			PAT_LONG:   pattern_on = ph < PH_LONG;
			PAT_SHORT:  pattern_on = ph < PH_SHORT;
			PAT_DOUBLE: pattern_on = (ph < PH_DBL) || (ph >= 2 * PH_DBL && ph < 3 * PH_DBL);
			default:    pattern_on = 1'b0;
		endcase
	endfunction

	// State
	logic [DATA_W-1:0]   ctrl_reg, ctrl_next;
	logic [DATA_W-1:0]   rdata_reg, rdata_next;
	logic [PHASE_W-1:0]  phase_reg, phase_next;
	logic [HB_CNT_W-1:0] round_cnt_reg, round_cnt_next;
	logic [HB_CNT_W-1:0] scan_cnt_reg, scan_cnt_next;
	logic                ms_led_reg, ms_led_next;
	logic                round_led_reg, round_led_next;
	logic                scan_led_reg, scan_led_next;
	logic                fault_reg, fault_next;
	lamp_pair_s          lamps_reg, lamps_next;
	logic                auto_key_reg, auto_key_next;
	logic                hand_key_reg, hand_key_next;
	logic                show_val_reg, show_val_next;
	logic                dashes_reg, dashes_next;
	logic                accept_reg, accept_next;
	logic                reject_reg, reject_next;
	logic                lamp_test;
	lamp_pat_e           auto_pat, hand_pat;
	logic                is_bypass_param, is_bypass_mon, is_drive_mon;

	assign lamp_test = ctrl_reg[CTRL_LAMP_TEST_BIT];

	// Register port; reads answer one cycle later, unmapped reads return zero
	always_comb begin
		ctrl_next  = ctrl_reg;
		rdata_next = '0;
		if (reg_write_i && reg_addr_i == REG_CTRL)
			ctrl_next = reg_wdata_i & DATA_W'(1 << CTRL_LAMP_TEST_BIT);
		if (reg_read_i) begin
			case (reg_addr_i)
				REG_CTRL:   rdata_next = ctrl_reg;
				REG_STATUS: rdata_next = {24'h00_0000, lamps_reg.hand_lamp, lamps_reg.auto_lamp,
						fault_reg, scan_led_reg, round_led_reg, ms_led_reg, ms_led_reg, drive_powered_i};
				REG_COUNT:  rdata_next = {7'h00, scan_cnt_reg, 7'h00, round_cnt_reg};
				default:    rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ctrl_reg  <= CTRL_RESET;
			rdata_reg <= '0;
		end else if (enable_i) begin
			ctrl_reg  <= ctrl_next;
			rdata_reg <= rdata_next;
		end
	end

	// Link activity and heartbeat counters
	always_comb begin
		ms_led_next    = ms_led_reg;
		round_cnt_next = round_cnt_reg;
		scan_cnt_next  = scan_cnt_reg;
		round_led_next = round_led_reg;
		scan_led_next  = scan_led_reg;
		if (link_transmit_i)
			ms_led_next = 1'b1;
		else if (link_receive_i)
			ms_led_next = 1'b0;
		if (round_done_i) begin
			if (round_cnt_reg == HB_LAST) begin
				round_cnt_next = '0;
				round_led_next = !round_led_reg;
			end else
				round_cnt_next = round_cnt_reg + 1'b1;
		end
		if (scan_done_i) begin
			if (scan_cnt_reg == HB_LAST) begin
				scan_cnt_next = '0;
				scan_led_next = !scan_led_reg;
			end else
				scan_cnt_next = scan_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ms_led_reg    <= 1'b0;
			round_cnt_reg <= '0;
			scan_cnt_reg  <= '0;
			round_led_reg <= 1'b0;
			scan_led_reg  <= 1'b0;
		end else if (enable_i) begin
			ms_led_reg    <= ms_led_next;
			round_cnt_reg <= round_cnt_next;
			scan_cnt_reg  <= scan_cnt_next;
			round_led_reg <= round_led_next;
			scan_led_reg  <= scan_led_next;
		end
	end

	// Blink phase, fault indicator and mode lamps share one free period
	always_comb begin
		phase_next = (phase_reg == PH_LAST) ? '0 : phase_reg + 1'b1;
		auto_pat   = pick_pattern(drive_state_i, 1'b1);
		hand_pat   = pick_pattern(drive_state_i, 1'b0);
		// Steady fault wins over flashing so a latched fault never looks transient
		if (lamp_test || fault_active_i)
			fault_next = 1'b1;
		else if (alarm_active_i || setting_consistency_error_i || tune_fault_i)
			fault_next = phase_reg < PH_LONG;
		else
			fault_next = 1'b0;
		lamps_next = '0;
		case (drive_state_i.mode)
			OP_AUTO: lamps_next.auto_lamp = pattern_on(auto_pat, phase_reg);
			OP_HAND: lamps_next.hand_lamp = pattern_on(hand_pat, phase_reg);
			default: lamps_next = '0;
		endcase
		if (lamp_test)
			lamps_next = '1;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			phase_reg <= '0;
			fault_reg <= 1'b0;
			lamps_reg <= '0;
		end else if (enable_i) begin
			phase_reg <= phase_next;
			fault_reg <= fault_next;
			lamps_reg <= lamps_next;
		end
	end

	// Keypad gating and parameter display policy
	always_comb begin
		auto_key_next   = key_auto_i && !programming_mode_i;
		hand_key_next   = key_hand_i && !programming_mode_i;
		is_bypass_param = !param_id_i.is_monitor && param_id_i.prefix == BYPASS_PREFIX;
		is_bypass_mon   = param_id_i.is_monitor && param_id_i.prefix == MON_PREFIX
				&& param_id_i.second == MON_BYPASS;
		is_drive_mon    = param_id_i.is_monitor && param_id_i.prefix == MON_PREFIX
				&& (param_id_i.second == MON_GRP1 || param_id_i.second == MON_GRP2
				|| param_id_i.second == MON_GRP4 || param_id_i.second == MON_GRP5);
		if (param_id_i.is_monitor) begin
			show_val_next = is_bypass_mon || drive_powered_i;
			dashes_next   = is_drive_mon && !drive_powered_i;
		end else begin
			// Drive-side values held in both places survive drive power loss
			show_val_next = is_bypass_param || drive_powered_i
					|| param_id_i.in_bypass_copy;
			dashes_next   = 1'b0;
		end
		accept_next = edit_req_i && !param_id_i.is_monitor
				&& (is_bypass_param || drive_powered_i);
		reject_next = edit_req_i && !accept_next;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			auto_key_reg <= 1'b0;
			hand_key_reg <= 1'b0;
			show_val_reg <= 1'b0;
			dashes_reg   <= 1'b0;
			accept_reg   <= 1'b0;
			reject_reg   <= 1'b0;
		end else if (enable_i) begin
			auto_key_reg <= auto_key_next;
			hand_key_reg <= hand_key_next;
			show_val_reg <= show_val_next;
			dashes_reg   <= dashes_next;
			accept_reg   <= accept_next;
			reject_reg   <= reject_next;
		end
	end

	// Outputs straight from flops
	assign reg_rdata_o           = rdata_reg;
	assign module_status_led_o   = ms_led_reg;
	assign network_status_led_o  = ms_led_reg;
	assign round_heartbeat_led_o = round_led_reg;
	assign scan_heartbeat_led_o  = scan_led_reg;
	assign fault_indicator_o     = fault_reg;
	assign lamps_o               = lamps_reg;
	assign auto_key_o            = auto_key_reg;
	assign hand_key_o            = hand_key_reg;
	assign show_value_o          = show_val_reg;
	assign show_dashes_o         = dashes_reg;
	assign edit_accept_o         = accept_reg;
	assign edit_reject_o         = reject_reg;

	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	AST_TX_LIT: assert property (enable_i && link_transmit_i |=> module_status_led_o && network_status_led_o)
		else $error("status LEDs not lit while transmitting");
	AST_RX_DARK: assert property (enable_i && !link_transmit_i && link_receive_i |=> !network_status_led_o)
		else $error("status LED not dark while receiving");
	// Heartbeats flip only on the last count of a run of pulses
	AST_ROUND_TOGGLE: assert property (enable_i && round_done_i && round_cnt_reg == HB_LAST
			|=> round_heartbeat_led_o != $past(round_heartbeat_led_o) && round_cnt_reg == '0)
		else $error("round heartbeat did not toggle at count end");
	AST_ROUND_HOLD: assert property (enable_i && !(round_done_i && round_cnt_reg == HB_LAST)
			|=> $stable(round_heartbeat_led_o))
		else $error("round heartbeat toggled early");
	AST_SCAN_TOGGLE: assert property (enable_i && scan_done_i && scan_cnt_reg == HB_LAST
			|=> scan_heartbeat_led_o != $past(scan_heartbeat_led_o) && scan_cnt_reg == '0)
		else $error("scan heartbeat did not toggle at count end");
	AST_SCAN_HOLD: assert property (enable_i && !(scan_done_i && scan_cnt_reg == HB_LAST)
			|=> $stable(scan_heartbeat_led_o))
		else $error("scan heartbeat toggled early");

	// Fault indicator: steady, flashing on the long phase, or dark
	AST_FAULT_STEADY: assert property (enable_i && fault_active_i |=> fault_indicator_o)
		else $error("fault indicator not steady on fault");
	AST_FLASH_ON: assert property (enable_i && !fault_active_i && phase_reg < PH_LONG
			&& (alarm_active_i || setting_consistency_error_i || tune_fault_i) |=> fault_indicator_o)
		else $error("flashing fault indicator dark in its on phase");
	AST_FLASH_OFF: assert property (enable_i && !lamp_test && !fault_active_i && phase_reg >= PH_LONG
			&& (alarm_active_i || setting_consistency_error_i || tune_fault_i) |=> !fault_indicator_o)
		else $error("flashing fault indicator lit in its off phase");
	AST_FAULT_DARK: assert property (enable_i && !lamp_test && !fault_active_i && !alarm_active_i
			&& !setting_consistency_error_i && !tune_fault_i |=> !fault_indicator_o)
		else $error("fault indicator lit with no fault");

	// Mode lamps: only the lamp of the selected mode may light, except in lamp test, which lights both
	AST_OFF_DARK: assert property (enable_i && !lamp_test && drive_state_i.mode == OP_OFF |=> lamps_o == '0)
		else $error("lamps lit in off mode");
	AST_HAND_SOLID: assert property (enable_i && !lamp_test && drive_state_i.mode == OP_HAND
			&& hand_pat == PAT_SOLID |=> lamps_o.hand_lamp && !lamps_o.auto_lamp)
		else $error("manual lamp not solid while running");
	AST_AUTO_SOLID: assert property (enable_i && !lamp_test && drive_state_i.mode == OP_AUTO
			&& drive_state_i.running && !drive_state_i.fast_stop && !drive_state_i.pi_sleep
			&& !drive_state_i.zero_ref && !drive_state_i.decel |=> lamps_o.auto_lamp && !lamps_o.hand_lamp)
		else $error("automatic lamp not solid while running");
	AST_AUTO_ONLY: assert property (enable_i && !lamp_test && drive_state_i.mode == OP_AUTO
			|=> !lamps_o.hand_lamp)
		else $error("manual lamp lit in automatic mode");
	AST_HAND_ONLY: assert property (enable_i && !lamp_test && drive_state_i.mode == OP_HAND
			|=> !lamps_o.auto_lamp)
		else $error("automatic lamp lit in manual mode");

	// Run keys
	AST_KEYS_IGNORED: assert property (enable_i && programming_mode_i |=> !auto_key_o && !hand_key_o)
		else $error("run key passed in programming mode");

	// Parameter and monitor display policy
	AST_SHARED_VALUE: assert property (enable_i && !param_id_i.is_monitor && param_id_i.in_bypass_copy
			|=> show_value_o)
		else $error("shared drive parameter value hidden");
	AST_DRIVE_HIDDEN: assert property (enable_i && !param_id_i.is_monitor && !param_id_i.in_bypass_copy
			&& param_id_i.prefix != BYPASS_PREFIX && !drive_powered_i |=> !show_value_o)
		else $error("drive-only parameter value shown without drive power");
	AST_EDIT_REFUSED: assert property (enable_i && edit_req_i && !drive_powered_i
			&& param_id_i.prefix != BYPASS_PREFIX |=> edit_reject_o && !edit_accept_o)
		else $error("drive parameter edit taken without drive power");
	AST_BYPASS_EDIT: assert property (enable_i && edit_req_i && !param_id_i.is_monitor
			&& param_id_i.prefix == BYPASS_PREFIX |=> edit_accept_o && !edit_reject_o)
		else $error("bypass parameter edit refused");
	AST_DASHES: assert property (enable_i && is_drive_mon && !drive_powered_i |=> show_dashes_o && !show_value_o)
		else $error("drive monitor not dashed");
	AST_BYPASS_MON: assert property (enable_i && param_id_i.is_monitor && param_id_i.prefix == MON_PREFIX
			&& param_id_i.second == MON_BYPASS |=> show_value_o && !show_dashes_o)
		else $error("bypass monitor not shown");

	// Main scenarios worth seeing at least once
	COV_AUTO_LONG: cover property (drive_state_i.mode == OP_AUTO && auto_pat == PAT_LONG ##1 lamps_o.auto_lamp);
	COV_HAND_DOUBLE: cover property (drive_state_i.mode == OP_HAND && hand_pat == PAT_DOUBLE);
	COV_ROUND_TOGGLE: cover property (round_done_i && round_cnt_reg == HB_LAST);
	COV_EDIT_REJECT: cover property (edit_reject_o);
	COV_FAULT_FLASH: cover property (!fault_active_i && alarm_active_i ##1 fault_indicator_o);

endmodule
`default_nettype wire

//--- verification/operator_view.sv
`default_nettype none
// Person reading the board: judges the LEDs only once the power-up show is over
module operator_view #(
	parameter int SETTLE_CYC = 20
) (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic reset_i,
	// Judgement window
	output logic      settled_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned wait_cnt;
	// Scaled down from seconds, or the run would last millions of cycles
	always @(posedge clock_i) begin
		if (reset_i) begin
			wait_cnt <= 0;
		end else if (wait_cnt < SETTLE_CYC) begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	assign settled_o = (wait_cnt >= SETTLE_CYC);
endmodule
`default_nettype wire

//--- verification/tb.sv
`default_nettype none
module tb;
	import bypass_led_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BLINK = 100;
	localparam int TIMEOUT_CYC = 20000;
	logic clock_i, reset_i, enable_i, reg_write_i, reg_read_i, link_transmit_i, link_receive_i;
	logic round_done_i, scan_done_i, fault_active_i, alarm_active_i, setting_consistency_error_i;
	logic tune_fault_i, key_auto_i, key_hand_i, programming_mode_i, drive_powered_i, edit_req_i;
	logic [ADDR_W-1:0] reg_addr_i;
	logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
	drive_state_s drive_state_i;
	param_id_s param_id_i;
	lamp_pair_s lamps_o;
	logic ms_led, ns_led, rd_led, sc_led, fault_o, auto_key_o, hand_key_o;
	logic show_value_o, show_dashes_o, edit_accept_o, edit_reject_o, settled;
	int bad_count = 0;
	int checks_done = 0;
	int cycle_count = 0;

	bypass_status_indicator_logic #(.BLINK_CYC(BLINK)) uut (
		.clock_i(clock_i), .reset_i(reset_i), .enable_i(enable_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
		.reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
		.link_transmit_i(link_transmit_i), .link_receive_i(link_receive_i),
		.round_done_i(round_done_i), .scan_done_i(scan_done_i),
		.fault_active_i(fault_active_i), .alarm_active_i(alarm_active_i),
		.setting_consistency_error_i(setting_consistency_error_i), .tune_fault_i(tune_fault_i),
		.drive_state_i(drive_state_i), .key_auto_i(key_auto_i), .key_hand_i(key_hand_i),
		.programming_mode_i(programming_mode_i), .param_id_i(param_id_i),
		.drive_powered_i(drive_powered_i), .edit_req_i(edit_req_i),
		.module_status_led_o(ms_led), .network_status_led_o(ns_led),
		.round_heartbeat_led_o(rd_led), .scan_heartbeat_led_o(sc_led),
		.fault_indicator_o(fault_o), .lamps_o(lamps_o), .auto_key_o(auto_key_o),
		.hand_key_o(hand_key_o), .show_value_o(show_value_o), .show_dashes_o(show_dashes_o),
		.edit_accept_o(edit_accept_o), .edit_reject_o(edit_reject_o)
	);

	operator_view #(.SETTLE_CYC(20)) viewer (
		.clock_i(clock_i), .reset_i(reset_i), .settled_o(settled)
	);

	// Free-running 10 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end

	task automatic end_of_test();
		$display("checks made %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Hang guard: well above the few thousand cycles the tests need
	always @(posedge clock_i) begin
		cycle_count <= cycle_count + 1;
		if (cycle_count == TIMEOUT_CYC) begin
			bad_count++;
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_write_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clock_i);
		reg_write_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_i);
		reg_read_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_read_i <= 1'b0;
		@(negedge clock_i);
		d = reg_rdata_o;
	endtask

	// Counts lit cycles over one whole blink period, so the phase at entry does not matter
	task automatic measure(output int a, output int h, output int f);
		a = 0;
		h = 0;
		f = 0;
		repeat (3) @(negedge clock_i);
		repeat (BLINK) begin
			@(negedge clock_i);
			if (lamps_o.auto_lamp === 1'b1) a++;
			if (lamps_o.hand_lamp === 1'b1) h++;
			if (fault_o === 1'b1) f++;
		end
	endtask

	task automatic lamp_case(input drive_state_s st, input int ea, input int eh);
		int a, h, f;
		@(posedge clock_i);
		drive_state_i <= st;
		measure(a, h, f);
		check("auto lamp on cycles", a, ea);
		check("hand lamp on cycles", h, eh);
	endtask

	task automatic fault_case(input logic [3:0] src, input int ef);
		int a, h, f;
		@(posedge clock_i);
		{fault_active_i, alarm_active_i, setting_consistency_error_i, tune_fault_i} <= src;
		measure(a, h, f);
		check("fault on cycles", f, ef);
	endtask

	task automatic param_case(input param_id_s id, input logic pw, input logic [3:0] exp);
		@(posedge clock_i);
		param_id_i <= id;
		drive_powered_i <= pw;
		edit_req_i <= 1'b1;
		@(posedge clock_i);
		edit_req_i <= 1'b0;
		@(negedge clock_i);
		check("value, dashes, accept, reject", {show_value_o, show_dashes_o, edit_accept_o, edit_reject_o}, exp);
	endtask

	// Inputs change only at rising edges; the last step shows enable low freezes the LEDs
	task automatic test_link();
		@(posedge clock_i);
		link_transmit_i <= 1'b1;
		@(posedge clock_i);
		link_transmit_i <= 1'b0;
		link_receive_i <= 1'b1;
		@(negedge clock_i);
		check("status leds while sending", {ms_led, ns_led}, 2'b11);
		@(posedge clock_i);
		link_receive_i <= 1'b0;
		link_transmit_i <= 1'b1;
		enable_i <= 1'b0;
		@(negedge clock_i);
		check("status leds while receiving", {ms_led, ns_led}, 2'b00);
		@(posedge clock_i);
		link_transmit_i <= 1'b0;
		enable_i <= 1'b1;
		@(negedge clock_i);
		check("status leds frozen by enable", {ms_led, ns_led}, 2'b00);
	endtask

	// 499 back-to-back pulses must leave the LEDs alone; the 500th flips them
	task automatic test_heartbeat();
		@(posedge clock_i);
		round_done_i <= 1'b1;
		scan_done_i <= 1'b1;
		repeat (HEARTBEAT_COUNT - 1) @(posedge clock_i);
		round_done_i <= 1'b0;
		scan_done_i <= 1'b0;
		@(negedge clock_i);
		check("heartbeats after 499", {rd_led, sc_led}, 2'b00);
		@(posedge clock_i);
		round_done_i <= 1'b1;
		scan_done_i <= 1'b1;
		@(posedge clock_i);
		round_done_i <= 1'b0;
		scan_done_i <= 1'b0;
		@(negedge clock_i);
		check("heartbeats after 500", {rd_led, sc_led}, 2'b11);
	endtask

	task automatic test_keys(input logic prog, input logic exp);
		@(posedge clock_i);
		programming_mode_i <= prog;
		key_auto_i <= 1'b1;
		key_hand_i <= 1'b1;
		@(posedge clock_i);
		key_auto_i <= 1'b0;
		key_hand_i <= 1'b0;
		@(negedge clock_i);
		check("run keys passed", {auto_key_o, hand_key_o}, {exp, exp});
		@(negedge clock_i);
		check("run keys after pulse", {auto_key_o, hand_key_o}, 2'b00);
	endtask

	task automatic test_regs();
		logic [31:0] d;
		reg_write(REG_CTRL, 32'hFFFF_FFFF);
		reg_read(REG_CTRL, d);
		check("control readback", d, 32'h0000_0001);
		lamp_case('0, BLINK, BLINK);
		// Lamp test on, both heartbeats lit, status LEDs dark, drive unpowered
		reg_read(REG_STATUS, d);
		check("status with lamp test", d, 32'h0000_00F8);
		reg_write(REG_CTRL, 32'h0000_0000);
		reg_read(8'h0C, d);
		check("unmapped read", d, 32'h0000_0000);
		@(posedge clock_i);
		drive_powered_i <= 1'b1;
		reg_read(REG_STATUS, d);
		check("status power bit", d[0], 1'b1);
	endtask

	initial begin
		reset_i = 1'b1;
		enable_i = 1'b1;
		{reg_write_i, reg_read_i, link_transmit_i, link_receive_i, round_done_i, scan_done_i} = '0;
		{fault_active_i, alarm_active_i, setting_consistency_error_i, tune_fault_i} = '0;
		{key_auto_i, key_hand_i, programming_mode_i, drive_powered_i, edit_req_i} = '0;
		reg_addr_i = '0;
		reg_wdata_i = '0;
		drive_state_i = '0;
		param_id_i = '0;
		repeat (6) @(posedge clock_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 100 && settled !== 1'b1; i++) @(posedge clock_i);
		test_link();
		test_heartbeat();
		fault_case(4'b1000, BLINK);
		fault_case(4'b1100, BLINK);
		fault_case(4'b0100, BLINK / 2);
		fault_case(4'b0010, BLINK / 2);
		fault_case(4'b0001, BLINK / 2);
		fault_case(4'b0000, 0);
		// Mode bits: running, dc_brake, zero_ref, decel, pi_sleep, ready, run_cmd, cycle_run, fast_stop
		lamp_case({OP_HAND, 9'b1_0000_0000}, 0, BLINK);
		lamp_case({OP_HAND, 9'b0_1000_0000}, 0, BLINK);
		lamp_case({OP_HAND, 9'b1_0100_0000}, 0, BLINK / 2);
		lamp_case({OP_HAND, 9'b0_0001_0000}, 0, BLINK / 2);
		lamp_case({OP_HAND, 9'b0_0000_1000}, 0, BLINK * SHORT_DUTY_PCT / 100);
		lamp_case({OP_HAND, 9'b0_0000_1010}, 0, BLINK * DOUBLE_ON_PCT / 50);
		lamp_case({OP_AUTO, 9'b1_1000_0000}, BLINK, 0);
		lamp_case({OP_AUTO, 9'b1_0010_0000}, BLINK / 2, 0);
		lamp_case({OP_AUTO, 9'b0_0000_1000}, BLINK * SHORT_DUTY_PCT / 100, 0);
		lamp_case({OP_AUTO, 9'b0_0000_0001}, BLINK * DOUBLE_ON_PCT / 50, 0);
		lamp_case({OP_OFF, 9'b1_0000_1001}, 0, 0);
		test_keys(1'b0, 1'b1);
		test_keys(1'b1, 1'b0);
		param_case('{8'h50, 8'h31, 1'b0, 1'b1}, 1'b0, 4'b1001);
		param_case('{8'h50, 8'h31, 1'b0, 1'b0}, 1'b0, 4'b0001);
		param_case('{8'h50, 8'h31, 1'b0, 1'b0}, 1'b1, 4'b1010);
		param_case('{BYPASS_PREFIX, 8'h31, 1'b0, 1'b0}, 1'b0, 4'b1010);
		param_case('{MON_PREFIX, MON_GRP1, 1'b1, 1'b0}, 1'b0, 4'b0101);
		param_case('{MON_PREFIX, MON_GRP2, 1'b1, 1'b0}, 1'b0, 4'b0101);
		param_case('{MON_PREFIX, MON_GRP4, 1'b1, 1'b0}, 1'b0, 4'b0101);
		param_case('{MON_PREFIX, MON_GRP5, 1'b1, 1'b0}, 1'b0, 4'b0101);
		param_case('{MON_PREFIX, MON_BYPASS, 1'b1, 1'b0}, 1'b0, 4'b1001);
		test_regs();
		end_of_test();
	end
endmodule
`default_nettype wire
